/* File: hw/system_status_diagnosis_readback.sv */
// Purpose: serial readback of the status and diagnosis words, with read side effects
// Assumes: data sampled on rising serial clock, driven after falling serial clock
// Notes:   serial pins and the alert pin pass a three-stage synchroniser
//
// Behaviour
// - edge alert flag sets on alert pin falling edge, clears when status is read.
// - alert level flag shows live alert pin level.
// - thermal warning flag is one while temperature exceeds the warning limit.
// - dev mode flag is one while development mode is active.
// - switch output flag is one while the switch output pin is driven high.
// - power-up flag is one after power-on, cleared once Normal mode is entered.
// - reset cause field takes every reset cause code and is never cleared.
// - reserved positions read zero in both words, one bit in status and two in diagnosis.
// - address 00 with read select one returns the diagnosis word.
// - read-only select zero also writes the frame fields to the mode register.
// - diagnosis reads are answered in every operating mode.
// - ground shift flag is one while ground shift is outside threshold.
// - fault codes F, E, C, D report stuck transmit, receive, bus, receive recessive.
// - fault codes 9, 8, 4, 6, 5 report wire shorts; 0 means no failure.
// - transceiver supply diag reads zero when overload disabled it, else one.
// - second regulator diag reads zero when overload disabled it, else one.
// - core supply diag latches zero on undervoltage, set to one on read.
// - transceiver mode field reports 11, 10, 01, or 00 when off or unpowered.
// - address 00 with read select zero returns the status word.
// - a frame without exactly sixteen clocks is ignored or raises an interrupt.
`timescale 1ns/1ps
`default_nettype none

module system_status_diagnosis_readback (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	// serial port pins
	input  wire logic        i_spi_cs_n,
	input  wire logic        i_spi_clk,
	input  wire logic        i_spi_data_in,
	output logic             o_spi_data_out,
	output logic             o_spi_data_out_en,
	// local alert pin
	input  wire logic        i_alert_pin,
	// status sources from chip logic
	input  wire logic        i_thermal_warning,
	input  wire logic        i_dev_mode,
	input  wire logic        i_switch_output,
	input  wire logic        i_transceiver_wake,
	input  wire logic        i_normal_mode_entered,
	input  wire logic        i_reset_event,
	input  wire logic [3:0]  i_reset_cause,
	// diagnosis sources from chip logic
	input  wire logic        i_ground_shift,
	input  wire logic [3:0]  i_transceiver_fault,
	input  wire logic        i_transceiver_supply_ok,
	input  wire logic        i_second_regulator_ok,
	input  wire logic        i_core_undervoltage,
	input  wire logic [1:0]  i_transceiver_mode,
	// frame results
	input  wire logic        i_count_fail_irq_en,
	output logic             o_mode_write,
	output logic [11:0]      o_mode_data,
	output logic             o_count_fail_irq
);

	// three-stage synchronisers; a level counts once stages two and three agree
	logic [2:0] sync_cs;
	logic [2:0] sync_clk;
	logic [2:0] sync_din;
	logic [2:0] sync_alert;
	logic       cs_level;
	logic       clk_level;
	logic       din_level;
	logic       alert_level;
	logic       next_cs_level;
	logic       next_clk_level;
	logic       next_alert_level;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			sync_cs    <= 3'h7;
			sync_clk   <= 3'h0;
			sync_din   <= 3'h0;
			sync_alert <= 3'h7;
		end else begin
			sync_cs    <= {sync_cs[1:0], i_spi_cs_n};
			sync_clk   <= {sync_clk[1:0], i_spi_clk};
			sync_din   <= {sync_din[1:0], i_spi_data_in};
			sync_alert <= {sync_alert[1:0], i_alert_pin};
		end
	end

	always_comb begin
		next_cs_level    = (sync_cs[1] == sync_cs[2]) ? sync_cs[2] : cs_level;
		next_clk_level   = (sync_clk[1] == sync_clk[2]) ? sync_clk[2] : clk_level;
		next_alert_level = (sync_alert[1] == sync_alert[2]) ? sync_alert[2] : alert_level;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			cs_level    <= 1'h1;
			clk_level   <= 1'h0;
			din_level   <= 1'h0;
			alert_level <= sys_status_pkg::RST_PIN_LEVEL;
		end else begin
			cs_level    <= next_cs_level;
			clk_level   <= next_clk_level;
			alert_level <= next_alert_level;
			if (sync_din[1] == sync_din[2]) begin
				din_level <= sync_din[2];
			end
		end
	end

	logic frame_start;
	logic frame_end;
	logic clk_rise;
	logic clk_fall;
	logic alert_fall;

	assign frame_start = cs_level & ~next_cs_level;
	assign frame_end   = ~cs_level & next_cs_level;
	assign clk_rise    = ~cs_level & ~clk_level & next_clk_level;
	assign clk_fall    = ~cs_level & clk_level & ~next_clk_level;
	assign alert_fall  = alert_level & ~next_alert_level;

	// latched status and diagnosis bits
	logic       edge_alert_flag;
	logic       power_up_flag;
	logic       core_supply_diag;
	logic [3:0] reset_cause_field;
	logic       status_read_done;
	logic       diag_read_done;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			edge_alert_flag <= sys_status_pkg::RST_EDGE_ALERT;
		end else if (alert_fall) begin
			edge_alert_flag <= 1'h1;
		end else if (status_read_done) begin
			edge_alert_flag <= 1'h0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			power_up_flag <= sys_status_pkg::RST_POWER_UP;
		end else if (i_reset_event && i_reset_cause == sys_status_pkg::CAUSE_POWER_ON) begin
			power_up_flag <= 1'h1;
		end else if (i_normal_mode_entered) begin
			power_up_flag <= 1'h0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			reset_cause_field <= sys_status_pkg::CAUSE_POWER_ON;
		end else if (i_reset_event) begin
			reset_cause_field <= i_reset_cause;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			core_supply_diag <= sys_status_pkg::RST_CORE_DIAG;
		end else if (i_core_undervoltage) begin
			core_supply_diag <= 1'h0;
		end else if (diag_read_done) begin
			core_supply_diag <= 1'h1;
		end
	end

	// live words
	sys_status_pkg::status_s status_now;
	sys_status_pkg::diag_s   diag_now;

	always_comb begin
		status_now                      = '0;
		status_now.reset_cause_field    = reset_cause_field;
		status_now.transceiver_wake     = i_transceiver_wake;
		status_now.reserved_a           = 1'h0;
		status_now.edge_alert_flag      = edge_alert_flag;
		status_now.alert_level_flag     = alert_level;
		status_now.thermal_warning_flag = i_thermal_warning;
		status_now.dev_mode_flag        = i_dev_mode;
		status_now.switch_output_flag   = i_switch_output;
		status_now.power_up_flag        = power_up_flag;
	end

	always_comb begin
		diag_now                         = '0;
		diag_now.ground_shift_flag       = i_ground_shift;
		diag_now.transceiver_fault_code  = i_transceiver_fault;
		diag_now.reserved_b              = 2'h0;
		diag_now.transceiver_supply_diag = i_transceiver_supply_ok;
		diag_now.second_regulator_diag   = i_second_regulator_ok;
		diag_now.core_supply_diag        = core_supply_diag;
		diag_now.transceiver_mode_field  = i_transceiver_supply_ok ? i_transceiver_mode
		                                                           : sys_status_pkg::XCVR_OFF_LINE;
	end

	// frame engine
	logic [15:0] status_snap;
	logic [15:0] diag_snap;
	logic [15:0] rx_shift;
	logic [15:0] reply_word;
	logic [4:0]  bit_count;
	logic [15:0] pick_word;
	logic        header_hit;
	logic        frame_ok;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			status_snap <= sys_status_pkg::RST_WORD;
			diag_snap   <= sys_status_pkg::RST_WORD;
		end else if (frame_start) begin
			status_snap <= status_now;
			diag_snap   <= diag_now;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rx_shift  <= sys_status_pkg::RST_WORD;
			bit_count <= 5'h00;
		end else if (frame_start) begin
			bit_count <= 5'h00;
		end else if (clk_rise) begin
			rx_shift <= {rx_shift[14:0], din_level};
			if (bit_count != sys_status_pkg::COUNT_MAX) begin
				bit_count <= bit_count + 5'h01;
			end
		end
	end

	// the selecting header bits are the four newest bits once four have arrived
	assign header_hit = rx_shift[sys_status_pkg::POS_ADDR_HI -: 2] == sys_status_pkg::ADDR_STATUS_DIAG;

	// header fields kept from the fourth falling clock to the end of the frame,
	// since by then the shift register holds data bits in those positions
	logic hdr_hit;
	logic hdr_read_sel;
	logic hdr_read_only;
	logic hdr_taken;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			hdr_hit       <= 1'h0;
			hdr_read_sel  <= 1'h0;
			hdr_read_only <= 1'h1;
			hdr_taken     <= 1'h0;
		end else if (frame_start) begin
			hdr_hit       <= 1'h0;
			hdr_read_sel  <= 1'h0;
			hdr_read_only <= 1'h1;
			hdr_taken     <= 1'h0;
		end else if (clk_fall && bit_count == sys_status_pkg::COUNT_HEADER) begin
			hdr_hit       <= header_hit;
			hdr_read_sel  <= rx_shift[sys_status_pkg::POS_READ_SEL];
			hdr_read_only <= rx_shift[sys_status_pkg::POS_READ_ONLY];
			hdr_taken     <= 1'h1;
		end
	end

	// index of the reply bit sent at this falling clock, valid inside the data field
	logic [3:0] reply_index;
	logic       reply_in_data;

	always_comb begin
		reply_index   = 4'(sys_status_pkg::COUNT_FRAME - 5'h01 - bit_count);
		reply_in_data = bit_count > sys_status_pkg::COUNT_HEADER
		                && bit_count < sys_status_pkg::COUNT_FRAME;
	end

	always_comb begin
		pick_word = sys_status_pkg::RST_WORD;
		if (header_hit) begin
			pick_word = rx_shift[sys_status_pkg::POS_READ_SEL] ? diag_snap
			                                                   : status_snap;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			reply_word     <= sys_status_pkg::RST_WORD;
			o_spi_data_out <= 1'h0;
		end else if (frame_start) begin
			reply_word     <= sys_status_pkg::RST_WORD;
			o_spi_data_out <= 1'h0;
		end else if (clk_fall) begin
			if (bit_count == sys_status_pkg::COUNT_HEADER) begin
				reply_word     <= pick_word;
				o_spi_data_out <= pick_word[11];
			end else if (reply_in_data) begin
				o_spi_data_out <= reply_word[reply_index];
			end else begin
				o_spi_data_out <= 1'h0;
			end
		end
	end

	assign o_spi_data_out_en = ~cs_level;

	logic mode_take;
	logic frame_bad;

	// side effects only after exactly sixteen clocks
	assign frame_ok  = frame_end && hdr_taken
	                   && bit_count == sys_status_pkg::COUNT_FRAME;
	assign frame_bad = frame_end && bit_count != sys_status_pkg::COUNT_FRAME;
	assign mode_take = frame_ok && hdr_hit && !hdr_read_only;

	// a status read clears the edge flag, a diagnosis read re-arms the core supply bit
	always_comb begin
		status_read_done = frame_ok && hdr_hit && !hdr_read_sel;
		diag_read_done   = frame_ok && hdr_hit && hdr_read_sel;
	end

	// the mode register takes the data field of a writing frame
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_mode_write <= 1'h0;
			o_mode_data  <= 12'h000;
		end else begin
			o_mode_write <= mode_take;
			if (mode_take) begin
				o_mode_data <= rx_shift[11:0];
			end
		end
	end

	// a refused frame pulses the count failure line when enabled
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_count_fail_irq <= 1'h0;
		end else begin
			o_count_fail_irq <= frame_bad && i_count_fail_irq_en;
		end
	end

endmodule

`default_nettype wire

/* File: hw/sys_status_pkg.sv */
// Purpose: constants and word layouts for the status and diagnosis readback block
// Assumes: 16-bit serial frames, address in bits 15:14, most significant bit first
// Notes:   the struct layouts match the status and diagnosis words bit for bit
package sys_status_pkg;

	// frame layout
	localparam int FRAME_BITS     = 16;
	localparam int HEADER_BITS    = 4;
	localparam int POS_ADDR_HI    = 3;
	localparam int POS_ADDR_LO    = 2;
	localparam int POS_READ_SEL   = 1;
	localparam int POS_READ_ONLY  = 0;
	localparam logic [1:0] ADDR_STATUS_DIAG = 2'h0;
	localparam logic [4:0] COUNT_HEADER     = 5'h04;
	localparam logic [4:0] COUNT_FRAME      = 5'h10;
	localparam logic [4:0] COUNT_MAX        = 5'h1F;

	// values after reset
	localparam logic [3:0] CAUSE_POWER_ON    = 4'h0;
	localparam logic       RST_POWER_UP      = 1'h1;
	localparam logic       RST_CORE_DIAG     = 1'h1;
	localparam logic       RST_EDGE_ALERT    = 1'h0;
	localparam logic       RST_PIN_LEVEL     = 1'h1;
	localparam logic [15:0] RST_WORD         = 16'h0000;

	// transceiver fault codes
	localparam logic [3:0] FAULT_NONE           = 4'h0;
	localparam logic [3:0] FAULT_HIGH_TO_SUPPLY = 4'h4;
	localparam logic [3:0] FAULT_LOW_TO_GROUND  = 4'h5;
	localparam logic [3:0] FAULT_HIGH_TO_GROUND = 4'h6;
	localparam logic [3:0] FAULT_LOW_TO_SUPPLY  = 4'h8;
	localparam logic [3:0] FAULT_WIRES_SHORTED  = 4'h9;
	localparam logic [3:0] FAULT_BUS_DOMINANT   = 4'hC;
	localparam logic [3:0] FAULT_RX_RECESSIVE   = 4'hD;
	localparam logic [3:0] FAULT_RX_DOMINANT    = 4'hE;
	localparam logic [3:0] FAULT_TX_DOMINANT    = 4'hF;

	// transceiver mode codes
	localparam logic [1:0] XCVR_OFF_LINE = 2'h0;
	localparam logic [1:0] XCVR_LISTEN   = 2'h1;
	localparam logic [1:0] XCVR_ON_LINE  = 2'h2;
	localparam logic [1:0] XCVR_ACTIVE   = 2'h3;

	typedef struct packed {
		logic [1:0] frame_address_bits;
		logic       read_select_bit;
		logic       read_only_select;
		logic [3:0] reset_cause_field;
		logic       transceiver_wake;
		logic       reserved_a;
		logic       edge_alert_flag;
		logic       alert_level_flag;
		logic       thermal_warning_flag;
		logic       dev_mode_flag;
		logic       switch_output_flag;
		logic       power_up_flag;
	} status_s;

	typedef struct packed {
		logic [1:0] frame_address_bits;
		logic       read_select_bit;
		logic       read_only_select;
		logic       ground_shift_flag;
		logic [3:0] transceiver_fault_code;
		logic [1:0] reserved_b;
		logic       transceiver_supply_diag;
		logic       second_regulator_diag;
		logic       core_supply_diag;
		logic [1:0] transceiver_mode_field;
	} diag_s;

endpackage

/* File: bench/sys_status_chk.sv */
// Purpose: port assertions for the status and diagnosis readback block
// Assumes: the count failure enable is held steady around frames
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module sys_status_chk (
	// clock and reset
	input wire logic        i_clock,
	input wire logic        i_sys_rst,
	// watched signals
	input wire logic        i_spi_cs_n,
	input wire logic        i_count_fail_irq_en,
	input wire logic        o_spi_data_out_en,
	input wire logic        o_mode_write,
	input wire logic [11:0] o_mode_data,
	input wire logic        o_count_fail_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	mode_pulse_a: assert property (o_mode_write |=> !o_mode_write)
		else $error("mode write longer than one cycle");
	mode_change_a: assert property ($changed(o_mode_data) |-> o_mode_write)
		else $error("mode data moved without a write");
	write_after_cs_a: assert property (o_mode_write |-> i_spi_cs_n && $past(i_spi_cs_n, 4))
		else $error("mode write before the frame closed");
	out_reset_a: assert property ($past(i_sys_rst) |-> o_mode_data == 12'h000 && !o_count_fail_irq)
		else $error("outputs not cleared by reset");
	irq_pulse_a: assert property (o_count_fail_irq |=> !o_count_fail_irq)
		else $error("count failure pulse too long");
	irq_enable_a: assert property (o_count_fail_irq |-> i_count_fail_irq_en)
		else $error("count failure pulse while disabled");
	irq_no_write_a: assert property (o_count_fail_irq |-> !o_mode_write ##1 !o_mode_write)
		else $error("refused frame wrote the mode register");
	oe_idle_a: assert property (i_spi_cs_n [*8] |-> !o_spi_data_out_en)
		else $error("data out driven while deselected");
	oe_active_a: assert property (!i_spi_cs_n [*8] |-> o_spi_data_out_en)
		else $error("data out not driven while selected");
	cover property (o_mode_write);
	cover property (o_count_fail_irq);
	cover property (o_spi_data_out_en);
endmodule
bind system_status_diagnosis_readback sys_status_chk chk_u (.i_clock, .i_sys_rst, .i_spi_cs_n,
	.i_count_fail_irq_en, .o_spi_data_out_en, .o_mode_write, .o_mode_data, .o_count_fail_irq);
`default_nettype wire

/* File: bench/host_model.sv */
// Purpose: host side of the serial link, one frame per go request
// Assumes: serial clock idle low, half period of five system clocks
// Notes:   received bits are shifted in at each rising serial clock
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// command
	input  wire logic        i_clock,
	input  wire logic        i_go,
	input  wire logic [15:0] i_word,
	input  wire logic [4:0]  i_clocks,
	// serial pins
	input  wire logic        i_miso,
	output logic             o_cs_n,
	output logic             o_sclk,
	output logic             o_mosi,
	// result
	output logic [15:0]      o_rx,
	output logic             o_done
);
	initial begin
		o_cs_n = 1'h1;
		o_sclk = 1'h0;
		o_mosi = 1'h0;
		o_rx = 16'h0000;
		o_done = 1'h0;
	end
	always begin
		@(posedge i_clock iff i_go);
		@(negedge i_clock);
		o_done = 1'h0;
		o_cs_n = 1'h0;
		for (int n = 0; n < i_clocks; n++) begin
			o_mosi = i_word[15 - (n % 16)];
			repeat (5) @(negedge i_clock);
			o_sclk = 1'h1;
			o_rx = {o_rx[14:0], i_miso};
			repeat (5) @(negedge i_clock);
			o_sclk = 1'h0;
		end
		repeat (5) @(negedge i_clock);
		o_cs_n = 1'h1;
		// deselected line must not keep its last value
		o_mosi = ~o_mosi;
		repeat (12) @(negedge i_clock);
		o_done = 1'h1;
	end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the status and diagnosis readback block
// Assumes: inputs change at the falling clock edge
// Notes:   frames come from the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        i_clock = 1'h0, i_sys_rst = 1'h1, i_alert_pin = 1'h1;
	logic        i_thermal_warning = 1'h0, i_dev_mode = 1'h0, i_switch_output = 1'h0;
	logic        i_transceiver_wake = 1'h0, i_normal_mode_entered = 1'h0, i_reset_event = 1'h0;
	logic [3:0]  i_reset_cause = 4'h0, i_transceiver_fault = 4'h0;
	logic        i_ground_shift = 1'h0, i_transceiver_supply_ok = 1'h1;
	logic        i_second_regulator_ok = 1'h1, i_core_undervoltage = 1'h0;
	logic [1:0]  i_transceiver_mode = 2'h0;
	logic        i_count_fail_irq_en = 1'h0, go = 1'h0, done;
	logic        i_spi_cs_n, i_spi_clk, i_spi_data_in;
	logic        o_spi_data_out, o_mode_write, o_count_fail_irq, oe;
	logic [11:0] o_mode_data, last_data;
	logic [15:0] word = 16'h0000, rx;
	logic [4:0]  nclk = 5'h10;
	int          err_count = 0, total_checks = 0, writes = 0, irqs = 0;
	always #10 i_clock = ~i_clock;
	system_status_diagnosis_readback dut_u (.i_clock, .i_sys_rst, .i_spi_cs_n, .i_spi_clk,
		.i_spi_data_in, .o_spi_data_out, .o_spi_data_out_en(oe), .i_alert_pin, .i_thermal_warning,
		.i_dev_mode, .i_switch_output, .i_transceiver_wake, .i_normal_mode_entered,
		.i_reset_event, .i_reset_cause, .i_ground_shift, .i_transceiver_fault,
		.i_transceiver_supply_ok, .i_second_regulator_ok, .i_core_undervoltage,
		.i_transceiver_mode, .i_count_fail_irq_en, .o_mode_write, .o_mode_data, .o_count_fail_irq);
	host_model host_u (.i_clock, .i_go(go), .i_word(word), .i_clocks(nclk), .i_miso(o_spi_data_out),
		.o_cs_n(i_spi_cs_n), .o_sclk(i_spi_clk), .o_mosi(i_spi_data_in), .o_rx(rx), .o_done(done));
	always @(posedge i_clock) begin
		if (o_mode_write === 1'h1) begin
			writes++;
			last_data = o_mode_data;
		end
		if (o_count_fail_irq === 1'h1) irqs++;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic frame(input logic [15:0] w, input logic [4:0] n);
		word = w;
		nclk = n;
		go = 1'h1;
		@(negedge i_clock);
		go = 1'h0;
		@(negedge i_clock);
		for (int k = 0; k < 3000 && done !== 1'h1; k++) @(negedge i_clock);
		check("frame done", {15'h0000, done}, 16'h0001);
	endtask
	// read-only frame at address 00, select picks diagnosis or status
	task automatic rd(input logic sel, input string name, input logic [15:0] exp);
		frame({2'h0, sel, 1'h1, 12'h000}, 5'h10);
		check(name, rx, exp);
	endtask
	task automatic t_reset;
		rd(1'h0, "status after reset", 16'h0011);
		check("no write", 16'(writes), 16'h0000);
		check("oe idle", {15'h0000, oe}, 16'h0000);
		$display("t_reset done");
	endtask
	task automatic t_live;
		{i_thermal_warning, i_dev_mode, i_switch_output, i_transceiver_wake} = 4'hF;
		rd(1'h0, "live status", 16'h009F);
		{i_thermal_warning, i_dev_mode, i_switch_output, i_transceiver_wake} = 4'h0;
		i_reset_cause = 4'hB;
		i_reset_event = 1'h1;
		@(negedge i_clock);
		i_reset_event = 1'h0;
		i_normal_mode_entered = 1'h1;
		@(negedge i_clock);
		i_normal_mode_entered = 1'h0;
		rd(1'h0, "cause and power flag", 16'h0B10);
		$display("t_live done");
	endtask
	task automatic t_edge;
		i_alert_pin = 1'h0;
		repeat (10) @(negedge i_clock);
		rd(1'h0, "edge set", 16'h0B20);
		rd(1'h0, "edge cleared", 16'h0B00);
		i_alert_pin = 1'h1;
		$display("t_edge done");
	endtask
	task automatic t_diag;
		logic [3:0] codes [10] = '{4'hF, 4'hE, 4'hC, 4'hD, 4'h9, 4'h8, 4'h4, 4'h6, 4'h5, 4'h0};
		for (int i = 0; i < 10; i++) begin
			i_transceiver_fault = codes[i];
			i_transceiver_mode = i[1:0];
			i_ground_shift = i[0];
			i_second_regulator_ok = i[1];
			rd(1'h1, "diag", {4'h0, i[0], codes[i], 3'h1, i[1], 1'h1, i[1:0]});
		end
		{i_ground_shift, i_second_regulator_ok, i_transceiver_supply_ok} = 3'h2;
		i_transceiver_mode = 2'h3;
		rd(1'h1, "supply off", 16'h000C);
		i_transceiver_supply_ok = 1'h1;
		i_transceiver_mode = 2'h0;
		$display("t_diag done");
	endtask
	task automatic t_core;
		i_core_undervoltage = 1'h1;
		@(negedge i_clock);
		i_core_undervoltage = 1'h0;
		rd(1'h1, "core low", 16'h0018);
		rd(1'h1, "core set by read", 16'h001C);
		$display("t_core done");
	endtask
	task automatic t_write;
		frame(16'h0A5C, 5'h10);
		check("write count", 16'(writes), 16'h0001);
		check("write data", {4'h0, last_data}, 16'h0A5C);
		$display("t_write done");
	endtask
	task automatic t_count;
		i_count_fail_irq_en = 1'h1;
		i_alert_pin = 1'h0;
		repeat (10) @(negedge i_clock);
		frame(16'h0000, 5'h0F);
		check("irq count", 16'(irqs), 16'h0001);
		check("refused write", 16'(writes), 16'h0001);
		rd(1'h0, "edge kept", 16'h0B20);
		i_count_fail_irq_en = 1'h0;
		frame(16'h1000, 5'h11);
		check("irq disabled", 16'(irqs), 16'h0001);
		i_alert_pin = 1'h1;
		$display("t_count done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge i_clock);
		i_sys_rst = 1'h0;
		repeat (6) @(negedge i_clock);
		t_reset;
		t_live;
		t_edge;
		t_diag;
		t_core;
		t_write;
		t_count;
		results;
	end
	initial begin
		#400000;
		err_count++;
		results;
	end
endmodule
`default_nettype wire
